//--- uhcsr_regs.v
// Command status, event status, event enable and control registers of a
// full/low-speed host controller, with its self-clearing software reset.
// Assumes a parallel bus where software presents a code and a data word in one cycle,
// and that hardware event strobes are synchronous to core_clk.
`include "uhcsr_defines.vh"

module uhcsr_regs #(
    parameter SRST_CYCLES = `UHCSR_SRST_MAX_CYC,
    parameter CNT_W = 11
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Register access port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_code,
    input wire [31:0] reg_wdata,
    output reg [31:0] reg_rdata_r,
    // Hardware event strobes
    input wire periodic_busy_at_eof,
    input wire [31:0] hw_event_set,
    // Interrupt request and status outputs
    output reg irq_r,
    output reg soft_rst_active_r,
    output reg [1:0] functional_state_r,
    output reg port_reset_drive_r
);

    // ****************************************************************
    // State machine encoding
    // ****************************************************************
    localparam ST_IDLE = 2'b01;
    localparam ST_RESET = 2'b10;

    reg [1:0] state_r;
    reg [CNT_W-1:0] tmr_r;
    reg srst_req_r;
    reg [31:0] evt_r;
    reg [31:0] ena_r;
    reg [31:0] ctl_r;
    reg [31:0] evt_nxt;
    reg [31:0] ena_nxt;
    reg [31:0] ctl_nxt;
    reg [31:0] rdata_nxt;
    reg [1:0] state_nxt;
    reg [CNT_W-1:0] tmr_nxt;
    reg srst_nxt;
    wire [1:0] ovr_cnt;
    wire overrun;
    wire cmd_wr;
    wire evt_wr;
    wire ena_wr;
    wire ena_clr;
    wire ctl_wr;
    wire srst_done;
    wire [31:0] cmd_view;

    // ****************************************************************
    // Decode
    // ****************************************************************
    assign overrun = periodic_busy_at_eof;
    assign cmd_wr = reg_wr && (reg_code == `UHCSR_CODE_CMD_WR);
    assign evt_wr = reg_wr && (reg_code == `UHCSR_CODE_EVT_WR);
    assign ena_wr = reg_wr && (reg_code == `UHCSR_CODE_ENA_WR);
    assign ena_clr = reg_wr && (reg_code == `UHCSR_CODE_ENA_CLR);
    assign ctl_wr = reg_wr && (reg_code == `UHCSR_CODE_CTL_WR);
    assign srst_done = (state_r == ST_RESET) &&
        (tmr_r == SRST_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1});

    // ****************************************************************
    // Overrun tally
    // ****************************************************************
    // The tally has no software write path at all.
    uhcsr_wrap_cnt #(
        .W(2)
    ) u_ovr_cnt (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .inc(overrun),
        .cnt_r(ovr_cnt)
    );

    // Reserved bits of the command register read zero.
    assign cmd_view = {14'h0000, ovr_cnt, 15'h0000, srst_req_r};

    // ****************************************************************
    // Software reset sequencer
    // ****************************************************************
    always @*
    begin
        state_nxt = state_r;
        tmr_nxt = tmr_r;
        srst_nxt = srst_req_r;
        case (state_r)
            ST_IDLE:
            begin
                tmr_nxt = {CNT_W{1'b0}};
                if (cmd_wr && reg_wdata[`UHCSR_CMD_SRST_BIT])
                begin
                    srst_nxt = 1'b1;
                    state_nxt = ST_RESET;
                end
            end
            ST_RESET:
            begin
                tmr_nxt = tmr_r + {{(CNT_W-1){1'b0}}, 1'b1};
                if (srst_done)
                begin
                    srst_nxt = 1'b0;
                    state_nxt = ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
                srst_nxt = 1'b0;
            end
        endcase
    end

    // ****************************************************************
    // Register next values
    // ****************************************************************
    always @*
    begin
        evt_nxt = evt_r;
        ena_nxt = ena_r;
        ctl_nxt = ctl_r;
        if (evt_wr)
        begin
            evt_nxt = evt_nxt & ~reg_wdata;
        end
        // Set after clear, so a same-cycle event is kept.
        evt_nxt = evt_nxt | (hw_event_set & `UHCSR_EVT_MASK);
        if (overrun)
        begin
            evt_nxt[`UHCSR_EVT_OVR_BIT] = 1'b1;
        end
        if (ena_wr)
        begin
            ena_nxt = ena_r | (reg_wdata & `UHCSR_ENA_MASK);
        end
        if (ena_clr)
        begin
            ena_nxt = ena_r & ~(reg_wdata & `UHCSR_ENA_MASK);
        end
        if (ctl_wr)
        begin
            ctl_nxt = reg_wdata & `UHCSR_CTL_MASK;
        end
        if (state_r == ST_RESET)
        begin
            // Enable register clears; control keeps preserved bits, FS goes to suspend.
            ena_nxt = `UHCSR_ZERO32;
            ctl_nxt = ctl_r & `UHCSR_PRESERVE_MASK;
            ctl_nxt[`UHCSR_CTL_FS_HI:`UHCSR_CTL_FS_LO] =
                `UHCSR_FS_SUSPEND;
        end
    end

    // ****************************************************************
    // Read mux
    // ****************************************************************
    always @*
    begin
        case (reg_code)
            `UHCSR_CODE_CMD_RD: rdata_nxt = cmd_view;
            `UHCSR_CODE_EVT_RD: rdata_nxt = evt_r;
            `UHCSR_CODE_ENA_RD: rdata_nxt = ena_r;
            `UHCSR_CODE_CTL_RD: rdata_nxt = ctl_r;
            default: rdata_nxt = `UHCSR_ZERO32;
        endcase
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    // Bus accesses during a software reset are the driver's fault; the
    // block still answers them but gives no guarantees.
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_r <= ST_IDLE;
            tmr_r <= {CNT_W{1'b0}};
            srst_req_r <= 1'b0;
            evt_r <= `UHCSR_ZERO32;
            ena_r <= `UHCSR_ZERO32;
            ctl_r <= `UHCSR_ZERO32;
            reg_rdata_r <= `UHCSR_ZERO32;
            irq_r <= 1'b0;
            soft_rst_active_r <= 1'b0;
            functional_state_r <= `UHCSR_FS_RESET;
            port_reset_drive_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            tmr_r <= tmr_nxt;
            srst_req_r <= srst_nxt;
            evt_r <= evt_nxt;
            ena_r <= ena_nxt;
            ctl_r <= ctl_nxt;
            if (reg_rd)
            begin
                reg_rdata_r <= rdata_nxt;
            end
            irq_r <= ena_r[`UHCSR_ENA_GATE_BIT] &&
                (|(evt_r & ena_r & `UHCSR_EVT_MASK));
            soft_rst_active_r <= srst_nxt;
            functional_state_r <= ctl_nxt[`UHCSR_CTL_FS_HI:`UHCSR_CTL_FS_LO];
            // Port reset follows only the hardware reset.
            port_reset_drive_r <= 1'b0;
        end
    end

endmodule // uhcsr_regs

//--- uhcsr_defines.vh
// Register offsets, field positions, reset values and timing counts for the
// host controller command, status and event register block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef UHCSR_DEFINES_VH
`define UHCSR_DEFINES_VH

// ****************************************************************
// Register codes
// ****************************************************************
`define UHCSR_CODE_CMD_RD 8'h02
`define UHCSR_CODE_CMD_WR 8'h82
`define UHCSR_CODE_EVT_RD 8'h03
`define UHCSR_CODE_EVT_WR 8'h83
`define UHCSR_CODE_ENA_RD 8'h04
`define UHCSR_CODE_ENA_WR 8'h84
`define UHCSR_CODE_ENA_CLR 8'h85
`define UHCSR_CODE_CTL_RD 8'h01
`define UHCSR_CODE_CTL_WR 8'h81

// ****************************************************************
// Field positions
// ****************************************************************
`define UHCSR_CMD_SRST_BIT 0
`define UHCSR_CMD_OVC_LO 16
`define UHCSR_CMD_OVC_HI 17
`define UHCSR_EVT_OVR_BIT 0
`define UHCSR_EVT_MASK 32'h0000007D
`define UHCSR_ENA_GATE_BIT 31
`define UHCSR_ENA_MASK 32'h8000007D
`define UHCSR_CTL_FS_LO 6
`define UHCSR_CTL_FS_HI 7
`define UHCSR_CTL_MASK 32'h000006FF

// ****************************************************************
// Reset values and encodings
// ****************************************************************
`define UHCSR_ZERO32 32'h00000000
`define UHCSR_OVC_RESET 2'h0
`define UHCSR_FS_RESET 2'h0
`define UHCSR_FS_SUSPEND 2'h3
`define UHCSR_PRESERVE_MASK 32'h00000200

// ****************************************************************
// Timing
// ****************************************************************
`define UHCSR_CLK_MHZ 100
`define UHCSR_SRST_MAX_US 10
`define UHCSR_SRST_MAX_CYC (`UHCSR_SRST_MAX_US * `UHCSR_CLK_MHZ)

`endif

//--- uhcsr_wrap_cnt.v
// Small wrapping counter used for the scheduling overrun tally.
// Assumes a synchronous active-high reset on core_clk.
`include "uhcsr_defines.vh"

module uhcsr_wrap_cnt #(
    parameter W = 2
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Count control
    input wire inc,
    // Count value
    output reg [W-1:0] cnt_r
);

    // ****************************************************************
    // Counter
    // ****************************************************************
    // The count wraps from all ones back to zero.
    always @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            cnt_r <= {W{1'b0}};
        end
        else if (inc)
        begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule // uhcsr_wrap_cnt

//--- uhcsr_props.sv
// Checker for the host controller command, status and event registers.
// Assumes a bind onto uhcsr_regs, seeing only its ports.
module uhcsr_props #(
    parameter SRST_CYCLES = 1000,
    parameter CNT_W = 11
) (
    // Clock and reset
    input wire core_clk,
    input wire sys_rst,
    // Register access port
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_code,
    input wire [31:0] reg_wdata,
    input wire [31:0] reg_rdata_r,
    // Events and status
    input wire periodic_busy_at_eof,
    input wire [31:0] hw_event_set,
    input wire irq_r,
    input wire soft_rst_active_r,
    input wire [1:0] functional_state_r,
    input wire port_reset_drive_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Counts the cycles for which the soft reset flag has stood high.
    logic [CNT_W:0] srst_cyc;
    logic ev_any;
    assign ev_any = |hw_event_set;
    always @(posedge core_clk)
    begin
        if (sys_rst || !soft_rst_active_r)
            srst_cyc <= '0;
        else
            srst_cyc <= srst_cyc + 1'b1;
    end
    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking dc @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    property p_go;
        reg_wr && reg_code == 8'h82 && reg_wdata[0] |=> soft_rst_active_r;
    endproperty
    a_go: assert property (p_go)
        else $error("no soft reset");
    property p_fs;
        $rose(soft_rst_active_r) |-> ##[1:2] functional_state_r == 2'h3;
    endproperty
    a_fs: assert property (p_fs)
        else $error("not suspended");
    property p_len;
        soft_rst_active_r |-> srst_cyc < SRST_CYCLES;
    endproperty
    a_len: assert property (p_len)
        else $error("soft reset too long");
    property p_port;
        !$past(sys_rst) |-> !port_reset_drive_r;
    endproperty
    a_port: assert property (p_port)
        else $error("port reset driven");
    property p_gate;
        (reg_wr && reg_code == 8'h85 && reg_wdata[31]) ##1
            !(reg_wr && reg_code == 8'h84) |=> !irq_r;
    endproperty
    a_gate: assert property (p_gate)
        else $error("irq without gate");
    property p_rise;
        $rose(irq_r) |-> $past(reg_wr, 2) ||
            $past(periodic_busy_at_eof, 2) || $past(ev_any, 2);
    endproperty
    a_rise: assert property (p_rise)
        else $error("irq rose uncaused");
    property p_fall;
        $fell(irq_r) |-> $past(reg_wr, 2) || $past(soft_rst_active_r, 2);
    endproperty
    a_fall: assert property (p_fall)
        else $error("irq fell uncaused");
    property p_res;
        reg_rd && reg_code == 8'h00 |=> reg_rdata_r == 32'h00000000;
    endproperty
    a_res: assert property (p_res)
        else $error("unmapped read");
endmodule // uhcsr_props

//--- uhcsr_host.sv
// Model of the driver software that reaches the registers over the bus.
// Assumes core_clk runs and inputs are sampled on its rising edge.
module uhcsr_host (
    // Clock
    input wire core_clk,
    // Register access port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_code,
    output logic [31:0] reg_wdata,
    input wire [31:0] reg_rdata_r
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    initial
    begin
        reg_wr = 1'h0;
        reg_rd = 1'h0;
        reg_code = 8'hFF;
        reg_wdata = 32'hFFFFFFFF;
    end
    // Callers watch the reset flag, not the bus, during soft reset.
    task automatic wr(input logic [7:0] c, input logic [31:0] d);
        @(negedge core_clk);
        reg_code = c;
        reg_wdata = d;
        reg_wr = 1'h1;
        @(negedge core_clk);
        reg_wr = 1'h0;
        reg_code = ~c;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] c, output logic [31:0] d);
        @(negedge core_clk);
        reg_code = c;
        reg_rd = 1'h1;
        @(negedge core_clk);
        reg_rd = 1'h0;
        reg_code = ~c;
        d = reg_rdata_r;
    endtask
endmodule // uhcsr_host

//--- uhcsr_regs_bench.sv
// Self-checking bench for the command, status and event registers.
// Assumes design, checker and host model are compiled first.
module uhcsr_regs_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam SRST = 8;
    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic eof_late = 1'h0;
    logic [31:0] ev_set = 32'h00000000;
    wire reg_wr;
    wire reg_rd;
    wire [7:0] reg_code;
    wire [31:0] reg_wdata;
    wire [31:0] rdata;
    wire irq;
    wire srst_on;
    wire prd;
    wire [1:0] fs;
    int mismatches = 0;
    int compares = 0;
    int n;
    always #5 core_clk = ~core_clk;
    uhcsr_host HOST (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_code(reg_code), .reg_wdata(reg_wdata), .reg_rdata_r(rdata));
    uhcsr_regs #(.SRST_CYCLES(SRST), .CNT_W(11)) DUT (.core_clk(core_clk),
        .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_code(reg_code), .reg_wdata(reg_wdata), .reg_rdata_r(rdata),
        .periodic_busy_at_eof(eof_late), .hw_event_set(ev_set),
        .irq_r(irq), .soft_rst_active_r(srst_on),
        .functional_state_r(fs), .port_reset_drive_r(prd));
    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rc(input logic [7:0] c, input logic [31:0] e);
        logic [31:0] d;
        HOST.rd(c, d);
        chk(d, e);
    endtask
    task automatic pulse(input logic o, input logic [31:0] ev);
        @(negedge core_clk);
        eof_late = o;
        ev_set = ev;
        @(negedge core_clk);
        eof_late = 1'h0;
        ev_set = 32'h00000000;
        repeat (2) @(negedge core_clk);
    endtask
    task automatic stop_test();
        $display("mismatches %0d compares %0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ****************************************************************
    // Sequence
    // ****************************************************************
    initial
    begin
        repeat (16) @(posedge core_clk);
        @(negedge core_clk);
        sys_rst = 1'h0;
        rc(8'h02, 32'h00000000);
        rc(8'h00, 32'h00000000);
        HOST.wr(8'h82, 32'hFFFFFFFE);
        rc(8'h02, 32'h00000000);
        for (int i = 1; i <= 5; i++)
        begin
            pulse(1'h1, 32'h00000000);
            rc(8'h02, 32'(i % 4) << 16);
            rc(8'h03, 32'h00000001);
        end
        HOST.wr(8'h83, 32'h00000000);
        rc(8'h03, 32'h00000001);
        HOST.wr(8'h83, 32'hFFFFFFFF);
        rc(8'h03, 32'h00000000);
        pulse(1'h0, 32'hFFFFFFFF);
        rc(8'h03, 32'h0000007D);
        HOST.wr(8'h84, 32'h00000001);
        pulse(1'h0, 32'h00000000);
        chk(irq, 1'h0);
        HOST.wr(8'h84, 32'h80000000);
        pulse(1'h0, 32'h00000000);
        chk(irq, 1'h1);
        HOST.wr(8'h83, 32'h00000001);
        pulse(1'h0, 32'h00000000);
        chk(irq, 1'h0);
        pulse(1'h1, 32'h00000000);
        chk(irq, 1'h1);
        HOST.wr(8'h85, 32'h80000000);
        pulse(1'h0, 32'h00000000);
        chk(irq, 1'h0);
        // Clear and overrun set of event bit 0 land on one edge.
        fork
            HOST.wr(8'h83, 32'h00000001);
            pulse(1'h1, 32'h00000000);
        join
        rc(8'h03, 32'h0000007D);
        HOST.wr(8'h81, 32'h000006BF);
        chk(fs, 2'h2);
        HOST.wr(8'h84, 32'h80000001);
        HOST.wr(8'h82, 32'h00000001);
        chk(srst_on, 1'h1);
        n = 0;
        while (srst_on === 1'h1 && n < 50)
        begin
            n++;
            @(negedge core_clk);
        end
        chk(n <= SRST + 1, 1'h1);
        if (n >= 50)
            stop_test();
        chk(fs, 2'h3);
        chk(prd, 1'h0);
        chk(irq, 1'h0);
        rc(8'h02, 32'h00030000);
        rc(8'h01, 32'h000002C0);
        rc(8'h04, 32'h00000000);
        stop_test();
    end
endmodule // uhcsr_regs_bench
bind uhcsr_regs uhcsr_props #(.SRST_CYCLES(SRST_CYCLES), .CNT_W(CNT_W))
    u_props (.core_clk(core_clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_code(reg_code), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .periodic_busy_at_eof(periodic_busy_at_eof),
    .hw_event_set(hw_event_set), .irq_r(irq_r),
    .soft_rst_active_r(soft_rst_active_r),
    .functional_state_r(functional_state_r),
    .port_reset_drive_r(port_reset_drive_r));
